// *** verilog/uart_pkg.sv ***
package uart_pkg;
  // register byte offsets
  localparam logic [4:0] A_CTRL  = 5'h00;
  localparam logic [4:0] A_BAUD  = 5'h04;
  localparam logic [4:0] A_TXD   = 5'h08;
  localparam logic [4:0] A_RXD   = 5'h0C;
  localparam logic [4:0] A_STAT  = 5'h10;
  localparam logic [4:0] A_ISTAT = 5'h14;
  localparam logic [4:0] A_IMASK = 5'h18;
  // control fields
  localparam int C_LEN   = 0;
  localparam int C_PAREN = 3;
  localparam int C_PODD  = 4;
  localparam int C_STOP2 = 5;
  localparam int C_TXEN  = 6;
  localparam int C_RXEN  = 7;
  localparam int C_AMODE = 8;
  localparam int C_SLEEP = 9;
  localparam int C_TXADR = 10;
  localparam logic [10:0] CTRL_RST = 11'h0C7;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // status fields
  localparam int S_TXBUF = 0;
  localparam int S_TXEMP = 1;
  localparam int S_RXBUF = 2;
  localparam int S_PERR  = 3;
  localparam int S_OVR   = 4;
  localparam int S_FERR  = 5;
  localparam int S_BRK   = 6;
  localparam int S_RXERR = 7;
  localparam int S_RXADR = 8;
  // interrupt status and mask fields
  localparam int I_TX  = 0;
  localparam int I_RX  = 1;
  localparam int I_ERR = 2;
  localparam int I_BRK = 3;
  // bit timing: eight ticks per bit, sampled at the fourth
  localparam logic [2:0] SUB_MID  = 3'h3;
  localparam logic [2:0] SUB_LAST = 3'h7;
  localparam logic [15:0] DIV0_LIM = 16'h0001;
  localparam logic [3:0] GAP_LAST = 4'h9;
  localparam logic [6:0] IDLE_TICKS = 7'h50;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [6:0] {
    TX_IDLE  = 7'b0000001,
    TX_GAP   = 7'b0000010,
    TX_START = 7'b0000100,
    TX_DATA  = 7'b0001000,
    TX_ADDR  = 7'b0010000,
    TX_PAR   = 7'b0100000,
    TX_STOP  = 7'b1000000
  } tx_state_t;
  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA  = 6'b000100,
    RX_ADDR  = 6'b001000,
    RX_PAR   = 6'b010000,
    RX_STOP  = 6'b100000
  } rx_state_t;
endpackage

// *** verilog/async_serial_unit.sv ***
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - bit rate clock/((div+1)*8), div zero clock/16
// - one start bit, one to eight data
// - optional parity, even or odd
// - one or two stop bits, checked
// - parity, overrun, framing, break errors flagged
// - idle-line and address-bit wake-up modes
// - transmitter and receiver enabled independently
// - holding buffer on both directions
// - tx buffer ready while holding buffer free
// - tx empty only when shifter idle
// - rx ready, break, summary error flags
// - separate tx/rx interrupt enables, break apart
// - all flags pollable, all but tx empty and rx address interrupt capable
// - nrz, each level held full bit
// - only serial tx and rx pins
module async_serial_unit
  import uart_pkg::*;
#(
  parameter int AW = 5
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  output var  logic [1:0]    s_axi_bresp,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output var  logic          serial_tx_pin,
  input  wire logic          serial_rx_pin,
  output var  logic          irq
);

  logic [10:0] ctrl_reg;
  logic [15:0] baud_divisor;
  logic [3:0]  istat_reg;
  logic [3:0]  imask_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick;
  logic [3:0]  len_m1;
  logic        wr_go;
  logic        rd_go;
  logic [4:0]  wa;
  logic [4:0]  ra;
  // tx side
  tx_state_t   tx_state_reg;
  logic [7:0]  tx_buf_reg;
  logic        tx_buf_full_reg;
  logic [7:0]  tx_sh_reg;
  logic [2:0]  tx_sub_reg;
  logic [3:0]  tx_bit_reg;
  logic        tx_par_reg;
  logic        tx_adr_reg;
  logic        tx_line;
  logic        tx_load;
  logic        tx_end;
  // rx side
  rx_state_t   rx_state_reg;
  logic [7:0]  rx_sh_reg;
  logic [2:0]  rx_sub_reg;
  logic [3:0]  rx_bit_reg;
  logic        rx_par_reg;
  logic        rx_zero_reg;
  logic        rx_perr_reg;
  logic        rx_ferr_reg;
  logic        rx_adr_reg;
  logic        rx_idlef_reg;
  logic        rx_prev_reg;
  logic [6:0]  idle_cnt_reg;
  logic [7:0]  rx_buf_reg;
  logic        rx_buf_adr_reg;
  logic        rx_full_reg;
  logic        st_perr_reg;
  logic        st_ovr_reg;
  logic        st_ferr_reg;
  logic        st_brk_reg;
  logic        rx_smp;
  logic        rx_end;
  logic        rx_fin;
  logic        rx_ferr_now;
  logic        rx_is_adr;
  logic        rx_take;
  logic        rx_brk;
  logic        rx_rd;
  logic [7:0]  rx_align;
  logic [3:0]  ev;
  logic [31:0] stat_word;

  // byte-lane merge for writable registers
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign wa     = 5'(s_axi_awaddr);
  assign ra     = 5'(s_axi_araddr);
  assign wr_go  = s_axi_awready;
  assign rd_go  = s_axi_arready;
  assign len_m1 = {1'b0, ctrl_reg[C_LEN +: 3]};

  // oversample tick, eight per bit
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = tick_cnt_reg >= ((baud_divisor == 16'h0000) ? DIV0_LIM : baud_divisor);

  // write channel: address and data taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa == A_CTRL || wa == A_BAUD || wa == A_TXD || wa == A_RXD ||
                         wa == A_STAT || wa == A_ISTAT || wa == A_IMASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= CTRL_RST;
      baud_divisor <= BAUD_RST;
      imask_reg    <= 4'h0;
    end else if (wr_go) begin
      if (wa == A_CTRL) begin
        ctrl_reg <= 11'(wmerge(32'(ctrl_reg), s_axi_wdata, s_axi_wstrb));
      end else if (wa == A_BAUD) begin
        baud_divisor <= 16'(wmerge(32'(baud_divisor), s_axi_wdata, s_axi_wstrb));
      end else if (wa == A_IMASK && s_axi_wstrb[0]) begin
        imask_reg <= s_axi_wdata[3:0];
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (ra == A_CTRL) begin
          s_axi_rdata <= 32'(ctrl_reg);
        end else if (ra == A_BAUD) begin
          s_axi_rdata <= 32'(baud_divisor);
        end else if (ra == A_TXD) begin
          s_axi_rdata <= 32'(tx_buf_reg);
        end else if (ra == A_RXD) begin
          s_axi_rdata <= 32'({rx_buf_adr_reg, rx_buf_reg});
        end else if (ra == A_STAT) begin
          s_axi_rdata <= stat_word;
        end else if (ra == A_ISTAT) begin
          s_axi_rdata <= 32'(istat_reg);
        end else if (ra == A_IMASK) begin
          s_axi_rdata <= 32'(imask_reg);
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // polled status word
  always_comb begin
    stat_word          = 32'h0000_0000;
    stat_word[S_TXBUF] = !tx_buf_full_reg;
    stat_word[S_TXEMP] = (tx_state_reg == TX_IDLE) && !tx_buf_full_reg;
    stat_word[S_RXBUF] = rx_full_reg;
    stat_word[S_PERR]  = st_perr_reg;
    stat_word[S_OVR]   = st_ovr_reg;
    stat_word[S_FERR]  = st_ferr_reg;
    stat_word[S_BRK]   = st_brk_reg;
    stat_word[S_RXERR] = st_perr_reg | st_ovr_reg | st_ferr_reg | st_brk_reg;
    stat_word[S_RXADR] = rx_buf_adr_reg;
  end

  // tick-aligned load keeps start bit whole; write wins
  assign tx_load = tick && (tx_state_reg == TX_IDLE) && tx_buf_full_reg && ctrl_reg[C_TXEN];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_reg      <= 8'h00;
      tx_buf_full_reg <= 1'b0;
    end else if (wr_go && wa == A_TXD && s_axi_wstrb[0]) begin
      tx_buf_reg      <= s_axi_wdata[7:0];
      tx_buf_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // transmit shifter
  assign tx_end = tick && (tx_sub_reg == SUB_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg    <= 8'h00;
      tx_sub_reg   <= 3'h0;
      tx_bit_reg   <= 4'h0;
      tx_par_reg   <= 1'b0;
      tx_adr_reg   <= 1'b0;
    end else begin
      if (tick) begin
        tx_sub_reg <= tx_sub_reg + 3'h1;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          tx_sub_reg <= 3'h0;
          tx_bit_reg <= 4'h0;
          tx_par_reg <= 1'b0;
          if (tx_load) begin
            tx_sh_reg    <= tx_buf_reg;
            tx_adr_reg   <= ctrl_reg[C_TXADR];
            tx_state_reg <= (!ctrl_reg[C_AMODE] && ctrl_reg[C_TXADR]) ? TX_GAP : TX_START;
          end
        end
        TX_GAP: begin
          if (tx_end) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == GAP_LAST) begin
              tx_bit_reg   <= 4'h0;
              tx_state_reg <= TX_START;
            end
          end
        end
        TX_START: begin
          if (tx_end) begin
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
            tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == len_m1) begin
              tx_bit_reg   <= 4'h0;
              tx_state_reg <= ctrl_reg[C_AMODE] ? TX_ADDR :
                              (ctrl_reg[C_PAREN] ? TX_PAR : TX_STOP);
            end
          end
        end
        TX_ADDR: begin
          if (tx_end) begin
            tx_state_reg <= ctrl_reg[C_PAREN] ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            tx_state_reg <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            if (ctrl_reg[C_STOP2] && tx_bit_reg == 4'h0) begin
              tx_bit_reg <= 4'h1;
            end else begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // line level per state
  always_comb begin
    tx_line = 1'b1;
    case (tx_state_reg)
      TX_START: tx_line = 1'b0;
      TX_DATA:  tx_line = tx_sh_reg[0];
      TX_ADDR:  tx_line = tx_adr_reg;
      TX_PAR:   tx_line = tx_par_reg ^ ctrl_reg[C_PODD];
      default:  tx_line = 1'b1;
    endcase
  end

  // pin register, level held whole bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_pin <= 1'b1;
    end else begin
      serial_tx_pin <= tx_line;
    end
  end

  // receive sequencing
  assign rx_smp      = tick && (rx_sub_reg == SUB_MID);
  assign rx_end      = tick && (rx_sub_reg == SUB_LAST);
  assign rx_ferr_now = rx_ferr_reg | !serial_rx_pin;
  assign rx_fin      = (rx_state_reg == RX_STOP) && rx_smp &&
                       !(ctrl_reg[C_STOP2] && rx_bit_reg == 4'h0 && serial_rx_pin);
  assign rx_is_adr   = ctrl_reg[C_AMODE] ? rx_adr_reg : rx_idlef_reg;
  assign rx_brk      = rx_fin && rx_ferr_now && rx_zero_reg && !serial_rx_pin;
  assign rx_take     = rx_fin && !rx_brk && (!ctrl_reg[C_SLEEP] || rx_is_adr);
  assign rx_align    = rx_sh_reg >> (4'h7 - len_m1);
  assign rx_rd       = rd_go && ra == A_RXD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 8'h00;
      rx_sub_reg   <= 3'h0;
      rx_bit_reg   <= 4'h0;
      rx_par_reg   <= 1'b0;
      rx_zero_reg  <= 1'b1;
      rx_perr_reg  <= 1'b0;
      rx_ferr_reg  <= 1'b0;
      rx_adr_reg   <= 1'b0;
      rx_idlef_reg <= 1'b0;
      rx_prev_reg  <= 1'b1;
      idle_cnt_reg <= 7'h00;
    end else begin
      rx_prev_reg <= serial_rx_pin;
      if (tick) begin
        rx_sub_reg <= rx_sub_reg + 3'h1;
      end
      // high-line run length for idle-line wake-up
      if (!serial_rx_pin || rx_state_reg != RX_IDLE) begin
        idle_cnt_reg <= 7'h00;
      end else if (tick && idle_cnt_reg != IDLE_TICKS) begin
        idle_cnt_reg <= idle_cnt_reg + 7'h01;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          rx_bit_reg  <= 4'h0;
          rx_par_reg  <= 1'b0;
          rx_zero_reg <= 1'b1;
          rx_perr_reg <= 1'b0;
          rx_ferr_reg <= 1'b0;
          rx_adr_reg  <= 1'b0;
          if (ctrl_reg[C_RXEN] && rx_prev_reg && !serial_rx_pin) begin
            rx_sub_reg   <= 3'h0;
            rx_idlef_reg <= idle_cnt_reg == IDLE_TICKS;
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_smp && serial_rx_pin) begin
            rx_state_reg <= RX_IDLE; // glitch, not a start
          end else if (rx_end) begin
            rx_state_reg <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_smp) begin
            rx_sh_reg   <= {serial_rx_pin, rx_sh_reg[7:1]};
            rx_par_reg  <= rx_par_reg ^ serial_rx_pin;
            rx_zero_reg <= rx_zero_reg & !serial_rx_pin;
          end
          if (rx_end) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == len_m1) begin
              rx_bit_reg   <= 4'h0;
              rx_state_reg <= ctrl_reg[C_AMODE] ? RX_ADDR :
                              (ctrl_reg[C_PAREN] ? RX_PAR : RX_STOP);
            end
          end
        end
        RX_ADDR: begin
          if (rx_smp) begin
            rx_adr_reg  <= serial_rx_pin;
            rx_zero_reg <= rx_zero_reg & !serial_rx_pin;
          end
          if (rx_end) begin
            rx_state_reg <= ctrl_reg[C_PAREN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (rx_smp) begin
            rx_perr_reg <= rx_par_reg ^ serial_rx_pin ^ ctrl_reg[C_PODD];
            rx_zero_reg <= rx_zero_reg & !serial_rx_pin;
          end
          if (rx_end) begin
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_smp) begin
            rx_ferr_reg <= rx_ferr_now;
          end
          if (rx_fin) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_end) begin
            rx_bit_reg <= 4'h1; // second stop bit
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // receive holding buffer and error flags, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_reg     <= 8'h00;
      rx_buf_adr_reg <= 1'b0;
      rx_full_reg    <= 1'b0;
      st_perr_reg    <= 1'b0;
      st_ovr_reg     <= 1'b0;
      st_ferr_reg    <= 1'b0;
      st_brk_reg     <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_buf_reg     <= rx_align;
        rx_buf_adr_reg <= rx_is_adr;
        rx_full_reg    <= 1'b1;
        st_perr_reg    <= rx_perr_reg | (st_perr_reg & !rx_rd);
        st_ferr_reg    <= rx_ferr_now | (st_ferr_reg & !rx_rd);
        st_ovr_reg     <= (rx_full_reg & !rx_rd) | (st_ovr_reg & !rx_rd);
      end else if (rx_rd) begin
        rx_full_reg <= 1'b0;
        st_perr_reg <= 1'b0;
        st_ferr_reg <= 1'b0;
        st_ovr_reg  <= 1'b0;
      end
      if (rx_brk) begin
        st_brk_reg <= 1'b1;
      end else if (rx_rd) begin
        st_brk_reg <= 1'b0;
      end
    end
  end

  // events into sticky interrupt status
  assign ev[I_TX]  = tx_load;
  assign ev[I_RX]  = rx_take;
  assign ev[I_ERR] = rx_take && (rx_perr_reg || rx_ferr_now || (rx_full_reg && !rx_rd));
  assign ev[I_BRK] = rx_brk;

  // write one to clear, new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_reg <= 4'h0;
    end else if (wr_go && wa == A_ISTAT && s_axi_wstrb[0]) begin
      istat_reg <= (istat_reg & ~s_axi_wdata[3:0]) | ev;
    end else begin
      istat_reg <= istat_reg | ev;
    end
  end

  // single level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_reg & imask_reg);
    end
  end

endmodule
`default_nettype wire

// *** tb/uart_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module uart_monitor
  import uart_pkg::*;
#(
  parameter int AW = 5
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          serial_tx_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0] hold_cnt_reg;
  logic       last_pin_reg;
  // length of the current level on the serial output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_reg <= 9'h1FF;
      last_pin_reg <= 1'b1;
    end else begin
      last_pin_reg <= serial_tx_pin;
      if (serial_tx_pin != last_pin_reg) begin
        hold_cnt_reg <= 9'h000;
      end else if (hold_cnt_reg != 9'h1FF) begin
        hold_cnt_reg <= hold_cnt_reg + 9'h001;
      end
    end
  end
  ready_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready differ");
  aw_gated_a: assert property (s_axi_awready |-> $past(s_axi_awvalid) && $past(s_axi_wvalid))
    else $error("write taken without address and data");
  b_answer_a: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck after handshake");
  bad_addr_a: assert property (s_axi_awready && (s_axi_awaddr > A_IMASK) |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  r_answer_a: assert property (s_axi_arready |-> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer late");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck after handshake");
  idle_high_a: assert property ($rose(aresetn) |-> serial_tx_pin)
    else $error("serial line not idle high after reset");
  nrz_hold_a: assert property (serial_tx_pin != last_pin_reg |-> hold_cnt_reg >= 9'h00F)
    else $error("serial level shorter than a bit");
endmodule
bind async_serial_unit uart_monitor #(.AW(AW)) mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_tx_pin(serial_tx_pin)
);
`default_nettype wire

// *** tb/remote_node.sv ***
`timescale 1ns/1ns
`default_nettype none
module remote_node (
  input wire logic aclk,
  input wire logic line_in,
  output var logic line_out
);
  int          bit_clks = 16;
  int          rx_n     = 9;
  int          rx_count = 0;
  logic [11:0] rx_bits  = '0;
  initial line_out = 1'b1;
  // frame out: start low, then bits lsb first, then idle high
  task automatic send(input logic [11:0] b, input int n);
    @(posedge aclk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      line_out <= b[i];
      repeat (bit_clks) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask
  // frame in: sampled mid-bit, timed from the start edge
  always begin
    @(negedge line_in);
    rx_bits = '0;
    repeat (bit_clks / 2) @(posedge aclk);
    for (int i = 0; i < rx_n; i++) begin
      repeat (bit_clks) @(posedge aclk);
      rx_bits[i] = line_in;
    end
    rx_count++;
  end
endmodule
`default_nettype wire

// *** tb/async_serial_uart_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module async_serial_uart_tb
  import uart_pkg::*;
;
  typedef struct packed {logic [10:0] ctrl; logic [15:0] baud; logic [7:0] ch;} row_t;
  row_t rows [5] = '{'{11'h0C7, 16'h0000, 8'hA5}, '{11'h0CE, 16'h0001, 8'h5A},
    '{11'h0FF, 16'h0003, 8'h3C}, '{11'h0C0, 16'h0001, 8'h01}, '{11'h0EC, 16'h0001, 8'h13}};
  logic [4:0]  rst_a [5] = '{A_CTRL, A_BAUD, A_STAT, A_ISTAT, A_IMASK};
  logic [31:0] rst_v [5] = '{{21'h0, CTRL_RST}, 32'h0, 32'h3, 32'h0, 32'h0};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  rsp;
  wire logic   awready, wready, bvalid, arready, rvalid, tx_line, rx_line, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          n_fail = 0, cmp_count = 0, cyc = 0, fb_n, c0;
  always #25 aclk = ~aclk;
  async_serial_unit #(.AW(5)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_tx_pin(tx_line), .serial_rx_pin(rx_line), .irq(irq));
  remote_node peer (.aclk(aclk), .line_in(tx_line), .line_out(rx_line));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // expected bits after start, lsb first; count in fb_n
  function automatic logic [11:0] fbits(input logic [10:0] c, input logic [7:0] ch, input logic adr);
    logic [11:0] b;
    logic        p;
    b = '0;
    p = c[C_PODD];
    fb_n = 0;
    for (int i = 0; i <= c[2:0]; i++) begin
      b[fb_n] = ch[i];
      p ^= ch[i];
      fb_n++;
    end
    if (c[C_AMODE]) begin
      b[fb_n] = adr;
      fb_n++;
    end
    if (c[C_PAREN]) begin
      b[fb_n] = p;
      fb_n++;
    end
    b[fb_n] = 1'b1;
    b[fb_n+1] = c[C_STOP2];
    fb_n += 1 + int'(c[C_STOP2]);
    return b;
  endfunction
  task automatic put(input logic [10:0] c, input logic [7:0] ch, input logic adr);
    logic [11:0] b;
    b = fbits(c, ch, adr);
    peer.send(b, fb_n);
  endtask
  task automatic txchk(input logic [10:0] c, input logic [7:0] ch, input logic adr);
    logic [11:0] b;
    int          n0;
    b = fbits(c, ch, adr);
    peer.rx_n = fb_n;
    n0 = peer.rx_count;
    wr(A_TXD, {24'h0, ch});
    wait (peer.rx_count != n0);
    chk({20'h0, peer.rx_bits}, {20'h0, b});
  endtask
  task automatic irqchk(input logic v);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      wr(A_BAUD, {16'h0, rows[r].baud});
      wr(A_CTRL, {21'h0, rows[r].ctrl});
      peer.bit_clks = (rows[r].baud == 16'h0 ? 2 : int'(rows[r].baud) + 1) * 8;
      fork
        txchk(rows[r].ctrl, rows[r].ch, 1'b0);
        put(rows[r].ctrl, rows[r].ch, 1'b0);
      join
      rd(A_STAT, d);
      chk(d & 32'h1FC, 32'h4);
      rd(A_RXD, d);
      chk(d, {24'h0, rows[r].ch & (8'hFF >> (7 - rows[r].ctrl[2:0]))});
      $display("row %0d done", r);
    end
    wr(A_BAUD, 32'h1);
    wr(A_CTRL, 32'h0C7);
    wr(A_IMASK, 32'h7);
    peer.bit_clks = 16;
    peer.send(12'h055, 9);
    rd(A_STAT, d);
    chk(d & 32'h0E8, 32'h0A0);
    rd(A_ISTAT, d);
    chk(d & 32'hC, 32'h4);
    irqchk(1'b1);
    rd(A_RXD, d);
    wr(A_ISTAT, 32'hF);
    irqchk(1'b0);
    $display("framing done");
    peer.send(12'h000, 9);
    rd(A_STAT, d);
    chk(d & 32'h0EC, 32'h0C0);
    rd(A_ISTAT, d);
    chk(d & 32'h8, 32'h8);
    irqchk(1'b0);
    wr(A_IMASK, 32'h8);
    irqchk(1'b1);
    wr(A_ISTAT, 32'hF);
    irqchk(1'b0);
    rd(A_RXD, d);
    $display("break done");
    wr(A_CTRL, 32'h0CF);
    peer.send(12'h303, 10);
    rd(A_STAT, d);
    chk(d & 32'h0E8, 32'h088);
    rd(A_RXD, d);
    chk(d, 32'h3);
    wr(A_CTRL, 32'h0C7);
    put(11'h0C7, 8'h41, 1'b0);
    put(11'h0C7, 8'h42, 1'b0);
    rd(A_STAT, d);
    chk(d & 32'h0FC, 32'h094);
    rd(A_RXD, d);
    chk(d, 32'h42);
    $display("parity and overrun done");
    wr(A_CTRL, 32'h7C7);
    txchk(11'h7C7, 8'h5A, 1'b1);
    put(11'h7C7, 8'h33, 1'b0);
    put(11'h7C7, 8'h66, 1'b1);
    rd(A_STAT, d);
    chk(d & 32'h114, 32'h104);
    rd(A_RXD, d);
    chk(d, 32'h166);
    wr(A_CTRL, 32'h6C7);
    txchk(11'h6C7, 8'h24, 1'b0);
    put(11'h6C7, 8'h77, 1'b0);
    rd(A_RXD, d);
    chk(d, 32'h177);
    $display("wake-up done");
    wr(A_CTRL, 32'h0C7);
    peer.rx_n = 9;
    c0 = peer.rx_count;
    wr(A_TXD, 32'h11);
    wr(A_TXD, 32'h22);
    rd(A_STAT, d);
    chk(d & 32'h3, 32'h0);
    wait (peer.rx_count == c0 + 1);
    chk({20'h0, peer.rx_bits}, {20'h0, fbits(11'h0C7, 8'h11, 1'b0)});
    wait (peer.rx_count == c0 + 2);
    chk({20'h0, peer.rx_bits}, {20'h0, fbits(11'h0C7, 8'h22, 1'b0)});
    repeat (20) @(posedge aclk);
    rd(A_STAT, d);
    chk(d & 32'h3, 32'h3);
    $display("double buffer done");
    rd(5'h1C, d);
    chk(d, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(5'h1C, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(rst_a[i], d);
      chk(d, rst_v[i]);
    end
    $display("reset done");
    complete_run();
  end
endmodule
`default_nettype wire
